// ==== hdl/fwd_pkg.sv ====
package fwd_pkg;

    // window register field layout
    localparam int          BASE_LSB        = 19;
    localparam int          BASE_W          = 13;
    localparam int          WP_BIT          = 8;
    localparam int          MASK_LSB        = 1;
    localparam int          MASK_W          = 5;
    localparam int          VALID_BIT       = 0;
    localparam int          OFFS_W          = 19;
    localparam logic [31:0] RSVD_MASK       = 32'h0007_fec0;
    localparam logic [31:0] WIN_RESET       = 32'h0000_0000;

    // back-door alias above the peripheral space base
    localparam logic [31:0] BACK_DOOR_OFFSET = 32'h0400_0000;

    // boot straps
    localparam logic [2:0]  MODE_SINGLE_CHIP = 3'h6;
    localparam logic [2:0]  MODE_MASTER      = 3'h7;
    localparam logic [1:0]  BOOT_INTERNAL    = 2'h0;
    localparam int          PIN_W            = 6;
    localparam logic [1:0]  STRAP_SETTLE     = 2'h3;

    // access timing in cycles
    localparam logic [2:0]  FLASH_RD_CYCLES  = 3'h2;
    localparam logic [2:0]  FLASH_WR_CYCLES  = 3'h2;
    localparam logic [2:0]  BD_EXTRA_CYCLES  = 3'h2;

    typedef struct packed {
        logic [BASE_W-1:0] base;
        logic              wp;
        logic [MASK_W-1:0] mask;
        logic              valid;
    } fwd_win_t;

    typedef enum logic [2:0] {
        SP_USER_DATA = 3'h0,
        SP_USER_CODE = 3'h1,
        SP_SUP_DATA  = 3'h2,
        SP_SUP_CODE  = 3'h3,
        SP_CPU       = 3'h4
    } fwd_space_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        fwd_space_t  space;
        logic        back_door;
    } fwd_acc_t;

    typedef enum logic {ST_STRAP, ST_RUN} fwd_init_t;

    function automatic logic [31:0] fwd_pack(input fwd_win_t w);
        logic [31:0] r;
        r = WIN_RESET;
        r[31:BASE_LSB] = w.base;
        r[WP_BIT] = w.wp;
        r[MASK_LSB +: MASK_W] = w.mask;
        r[VALID_BIT] = w.valid;
        return r;
    endfunction : fwd_pack

    function automatic fwd_win_t fwd_unpack(input logic [31:0] d);
        fwd_win_t w;
        w.base  = d[31:BASE_LSB];
        w.wp    = d[WP_BIT];
        w.mask  = d[MASK_LSB +: MASK_W];
        w.valid = d[VALID_BIT];
        return w;
    endfunction : fwd_unpack

endpackage : fwd_pkg

// ==== hdl/fwd_sync.sv ====
`timescale 1ns/10ps
module fwd_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                meta_q[i] <= 1'b0;
                q[i]      <= 1'b0;
            end else if (clk_en) begin
                meta_q[i] <= d[i];
                q[i]      <= meta_q[i];
            end
        end
    end
endmodule : fwd_sync

// ==== hdl/fwd_flash_window.sv ====
`timescale 1ns/10ps
module fwd_flash_window
    import fwd_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              reset_config_n,
    input  wire logic [2:0]        mode_pins,
    input  wire logic [1:0]        boot_sel_pins,
    input  wire logic              flash_secured,
    input  wire logic              ctl_move_wr,
    input  wire logic [31:0]       ctl_move_wdata,
    input  wire logic              dbg_wr,
    input  wire logic              dbg_rd,
    input  wire logic [31:0]       dbg_wdata,
    output logic      [31:0]       dbg_rdata,
    output logic                   dbg_rvalid,
    input  wire logic              bd_en_wr,
    input  wire logic              bd_en_wdata,
    output logic                   back_door_enable,
    input  wire logic [31:0]       peripheral_space_base,
    input  wire logic              acc_req,
    input  wire fwd_acc_t          acc,
    output logic                   acc_ready,
    output logic                   acc_ack,
    output logic                   acc_error,
    output logic                   acc_non_flash,
    output logic                   flash_strobe,
    output logic                   flash_write,
    output logic      [OFFS_W-1:0] flash_offset,
    output logic                   window_valid,
    output logic                   init_done
);
    fwd_win_t         win_q;
    fwd_win_t         win_d;
    fwd_win_t         wr_img;
    fwd_init_t        state_q;
    logic [1:0]       settle_q;
    logic [PIN_W-1:0] pins_s;
    logic [2:0]       lat_q;
    logic             busy_q;
    logic             ready_q;
    logic             ack_q;
    logic             err_q;
    logic             nonflash_q;
    logic             strobe_q;
    logic             fwrite_q;
    logic [OFFS_W-1:0] offset_q;
    logic             bd_en_q;
    logic [BASE_W+MASK_W:0] keep_q;
    logic             valid_q;
    logic [31:0]      dbg_rdata_q;
    logic             dbg_rvalid_q;

    // straps come from pins, so they are synchronised first
    fwd_sync #(.W(PIN_W)) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .d       ({reset_config_n, mode_pins, boot_sel_pins}),
        .q       (pins_s)
    );

    wire       cfg_asserted = !pins_s[5];
    wire [2:0] mode_s       = pins_s[4:2];
    wire [1:0] boot_s       = pins_s[1:0];

    // strap decode
    wire mode_single  = cfg_asserted && (mode_s == MODE_SINGLE_CHIP);
    wire mode_master  = cfg_asserted && (mode_s == MODE_MASTER)
                        && (boot_s == BOOT_INTERNAL);
    wire strap_valid  = flash_secured || !cfg_asserted
                        || mode_single || mode_master;
    wire strap_done   = (state_q == ST_STRAP) && (settle_q == STRAP_SETTLE);

    // register write path; debug wins over a simultaneous core write
    wire        win_wr   = ctl_move_wr || dbg_wr;
    wire [31:0] wr_word  = dbg_wr ? dbg_wdata : ctl_move_wdata;
    assign      wr_img   = fwd_unpack(wr_word & ~RSVD_MASK);
    assign      win_d    = win_wr ? wr_img
                         : strap_done ? {win_q.base, win_q.wp, win_q.mask, strap_valid}
                         : win_q;

    // access decode
    wire             space_legal = (acc.space <= SP_CPU);
    wire [2:0]       space_idx   = acc.space;
    wire             space_block = !space_legal || win_q.mask[space_idx];
    wire             addr_match  = (acc.addr[31:BASE_LSB] == win_q.base);
    wire             win_hit     = !acc.back_door && win_q.valid
                                   && addr_match && !space_block;
    wire             wp_viol     = win_hit && acc.write && win_q.wp;
    // other masters arrive through the alias region
    wire [31:0]      bd_base     = peripheral_space_base + BACK_DOOR_OFFSET;
    wire [31:0]      bd_delta    = acc.addr - bd_base;
    wire             bd_in       = (bd_delta[31:BASE_LSB] == '0);
    wire             bd_ok       = acc.back_door && bd_en_q && bd_in;
    wire             take        = clk_en && acc_req && ready_q;
    wire             go          = (win_hit && !wp_viol) || bd_ok;
    wire [OFFS_W-1:0] offs_d     = acc.back_door ? bd_delta[OFFS_W-1:0]
                                                 : acc.addr[OFFS_W-1:0];
    // alias path pays the extra bridge cycles on reads only
    wire [2:0]       lat_load    = acc.write ? FLASH_WR_CYCLES
                                 : acc.back_door ? 3'(FLASH_RD_CYCLES + BD_EXTRA_CYCLES)
                                 : FLASH_RD_CYCLES;
    wire             lat_end     = busy_q && (lat_q == 3'h1);

    // base, protect and masks have no reset: a chip reset must leave them as written
    assign win_q = {keep_q, valid_q};

    always_ff @(posedge mclk) begin
        if (clk_en) begin
            keep_q <= {win_d.base, win_d.wp, win_d.mask};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            valid_q <= 1'b0;
        end else if (clk_en) begin
            valid_q <= win_d.valid;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= ST_STRAP;
            settle_q <= 2'h0;
        end else if (clk_en && state_q == ST_STRAP) begin
            settle_q <= settle_q + 2'h1;
            if (strap_done) begin
                state_q <= ST_RUN;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bd_en_q <= 1'b0;
        end else if (clk_en && bd_en_wr) begin
            bd_en_q <= bd_en_wdata;
        end
    end

    // the core side has no read port at all; only debug sees the image
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dbg_rdata_q  <= 32'h0000_0000;
            dbg_rvalid_q <= 1'b0;
        end else if (clk_en) begin
            dbg_rvalid_q <= dbg_rd;
            if (dbg_rd) begin
                dbg_rdata_q <= fwd_pack(win_q);
            end
        end
    end

    // one accepted access in flight; ready drops until its ack, and stays high after a refused one
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q  <= 1'b0;
            ready_q <= 1'b0;
            lat_q   <= 3'h0;
        end else if (clk_en) begin
            if (take) begin
                busy_q  <= go;
                ready_q <= !go;
                lat_q   <= lat_load;
            end else if (lat_end) begin
                busy_q  <= 1'b0;
                ready_q <= 1'b1;
            end else if (busy_q) begin
                lat_q <= lat_q - 3'h1;
            end else begin
                ready_q <= (state_q == ST_RUN);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q      <= 1'b0;
            err_q      <= 1'b0;
            nonflash_q <= 1'b0;
            strobe_q   <= 1'b0;
        end else if (clk_en) begin
            ack_q      <= lat_end;
            err_q      <= take && (wp_viol || (acc.back_door && !bd_ok));
            nonflash_q <= take && !acc.back_door && !win_hit;
            strobe_q   <= take && go;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fwrite_q <= 1'b0;
            offset_q <= '0;
        end else if (clk_en && take && go) begin
            fwrite_q <= acc.write;
            offset_q <= offs_d;
        end
    end

    assign dbg_rdata        = dbg_rdata_q;
    assign dbg_rvalid       = dbg_rvalid_q;
    assign back_door_enable = bd_en_q;
    assign acc_ready        = ready_q;
    assign acc_ack          = ack_q;
    assign acc_error        = err_q;
    assign acc_non_flash    = nonflash_q;
    assign flash_strobe     = strobe_q;
    assign flash_write      = fwrite_q;
    assign flash_offset     = offset_q;
    assign window_valid     = win_q.valid;
    assign init_done        = (state_q == ST_RUN);

    // checks; a frozen clock enable aborts an attempt
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n || !clk_en);

    AST_RD_LATENCY: assert property (
        take && win_hit && !acc.write |-> ##1 !ack_q [*2] ##1 ack_q)
        else $error("direct read not answered on the third cycle");

    AST_BD_LATENCY: assert property (
        take && bd_ok && !acc.write |-> ##1 !ack_q [*4] ##1 ack_q)
        else $error("back-door read not answered two cycles after a direct one");

    AST_WP_ERROR: assert property (
        take && win_hit && acc.write && win_q.wp |=> err_q && !strobe_q)
        else $error("protected write not refused with access error");

    AST_INVALID_MISS: assert property (
        take && !acc.back_door && !win_q.valid |=> nonflash_q && !strobe_q)
        else $error("access reached flash through an invalid window");

    AST_MASK_BLOCK: assert property (
        take && !acc.back_door && space_block |=> nonflash_q && !strobe_q)
        else $error("masked address space reached flash");

    AST_DBG_RSVD_ZERO: assert property (
        dbg_rvalid_q |-> (dbg_rdata_q & RSVD_MASK) == 32'h0000_0000)
        else $error("reserved bits read back non-zero");

    AST_DBG_READBACK: assert property (
        dbg_rd |=> dbg_rdata_q == fwd_pack($past(win_q)))
        else $error("debug read does not show the register");

    AST_BASE_WRITE: assert property (
        ctl_move_wr && !dbg_wr |=> win_q.base == $past(ctl_move_wdata[31:BASE_LSB]))
        else $error("core write did not load the base field");

    AST_BD_EN_RESET: assert property (
        $rose(reset_n) |-> !bd_en_q)
        else $error("back-door enable not clear after reset");

    AST_STRAP_VALID: assert property (
        strap_done && !win_wr |=> win_q.valid == $past(strap_valid))
        else $error("valid bit not loaded from boot straps");

    AST_BD_EN_OFF: assert property (
        take && acc.back_door && !bd_en_q |=> err_q && !strobe_q)
        else $error("back-door access taken while back-door enable is clear");

    AST_WR_ALLOWED: assert property (
        take && win_hit && acc.write && !win_q.wp |=> strobe_q && fwrite_q)
        else $error("unprotected write did not reach flash");

    AST_REFUSE_READY: assert property (
        take && !go |=> ready_q && !strobe_q && !busy_q)
        else $error("refused access left the port busy");

    AST_STROBE_OFFSET: assert property (
        take && go |=> strobe_q && offset_q == $past(offs_d))
        else $error("flash strobe or offset wrong after an accepted access");

    AST_WRITE_IMAGE: assert property (
        win_wr |=> fwd_pack(win_q) == ($past(wr_word) & ~RSVD_MASK))
        else $error("register image does not match the written word");

    AST_NO_READY_STRAP: assert property (
        state_q == ST_STRAP |-> !ready_q && !strobe_q)
        else $error("access port ready before boot straps were captured");

    COV_DIRECT_READ: cover property (take && win_hit && !acc.write ##3 ack_q);
    COV_BD_READ:     cover property (take && bd_ok && !acc.write ##5 ack_q);
    COV_WP_ERR:      cover property (take && wp_viol ##1 err_q);
    COV_STRAP_OFF:   cover property (strap_done && !strap_valid);

endmodule : fwd_flash_window

// ==== tb/fwd_core_model.sv ====
`timescale 1ns/10ps
module fwd_core_model
    import fwd_pkg::*;
(
    input  wire logic mclk,
    output logic      acc_req,
    output fwd_acc_t  acc,
    input  wire logic acc_ready,
    input  wire logic acc_ack,
    input  wire logic acc_error,
    input  wire logic acc_non_flash
);
    initial begin
        acc_req = 1'b0;
        acc     = '0;
    end

    // code: 0 ack, 1 error, 2 non-flash, 3 no answer; lat counts cycles after the take edge
    task automatic access(input logic [31:0] a, input logic w, input fwd_space_t s,
                          input logic bd, output int code, output int lat);
        logic taken;
        taken = 1'b0;
        code  = 3;
        lat   = 0;
        @(negedge mclk);
        acc_req = 1'b1;
        acc     = '{addr: a, write: w, space: s, back_door: bd};
        for (int i = 0; i < 20 && !taken; i++) begin
            taken = acc_ready;
            @(negedge mclk);
        end
        acc_req  = 1'b0;
        // released bus shows no stale address
        acc.addr = ~a;
        for (int n = 1; n <= 20 && taken && code == 3; n++) begin
            if (acc_ack === 1'b1) begin
                code = 0;
            end else if (acc_error === 1'b1) begin
                code = 1;
            end else if (acc_non_flash === 1'b1) begin
                code = 2;
            end
            lat = n;
            if (code == 3) begin
                @(negedge mclk);
            end
        end
    endtask : access
endmodule : fwd_core_model

// ==== tb/fwd_flash_window_tb.sv ====
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module fwd_flash_window_tb
    import fwd_pkg::*;
;
    // {cfg_n, mode[2:0], boot[1:0], secured}
    localparam logic [6:0] STRAPS [8] = '{7'h40, 7'h30, 7'h36, 7'h38, 7'h3a, 7'h3c, 7'h00, 7'h01};
    logic              mclk, reset_n, clk_en, reset_config_n, flash_secured;
    logic              ctl_move_wr, dbg_wr, dbg_rd, bd_en_wr, bd_en_wdata, dbg_rvalid;
    logic [2:0]        mode_pins;
    logic [1:0]        boot_sel_pins;
    logic [31:0]       ctl_move_wdata, dbg_wdata, dbg_rdata, peripheral_space_base;
    logic              back_door_enable, acc_req, acc_ready, acc_ack, acc_error;
    logic              acc_non_flash, flash_strobe, flash_write, window_valid, init_done;
    logic [OFFS_W-1:0] flash_offset;
    fwd_acc_t          acc;
    int                mismatches, checked;
    int                strobes = 0;
    logic              exp_v;

    fwd_flash_window uut (.mclk, .reset_n, .clk_en, .reset_config_n, .mode_pins,
        .boot_sel_pins, .flash_secured, .ctl_move_wr, .ctl_move_wdata, .dbg_wr, .dbg_rd,
        .dbg_wdata, .dbg_rdata, .dbg_rvalid, .bd_en_wr, .bd_en_wdata, .back_door_enable,
        .peripheral_space_base, .acc_req, .acc, .acc_ready, .acc_ack, .acc_error,
        .acc_non_flash, .flash_strobe, .flash_write, .flash_offset, .window_valid, .init_done);
    fwd_core_model core (.mclk, .acc_req, .acc, .acc_ready, .acc_ack, .acc_error,
        .acc_non_flash);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // strobe is a one-cycle pulse, so each one is seen at exactly one falling edge
    always @(negedge mclk) begin
        if (flash_strobe === 1'b1) begin
            strobes++;
        end
    end

    task automatic report_and_stop;
        $display("counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic do_reset(input logic [6:0] s);
        {reset_config_n, mode_pins, boot_sel_pins, flash_secured} = s;
        reset_n = 1'b0;
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
        for (int i = 0; i < 12 && init_done !== 1'b1; i++) @(negedge mclk);
        if (init_done !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        @(negedge mclk);
    endtask : do_reset

    // kind 0 core move, 1 debug, 2 back-door enable
    task automatic wr_reg(input int kind, input logic [31:0] d);
        @(negedge mclk);
        ctl_move_wr    = kind == 0;
        dbg_wr         = kind == 1;
        bd_en_wr       = kind == 2;
        ctl_move_wdata = d;
        dbg_wdata      = d;
        bd_en_wdata    = d[0];
        @(negedge mclk);
        {ctl_move_wr, dbg_wr, bd_en_wr} = 3'h0;
    endtask : wr_reg

    task automatic rd_chk(input logic [31:0] exp);
        @(negedge mclk);
        dbg_rd = 1'b1;
        @(negedge mclk);
        dbg_rd = 1'b0;
        `CHK("rvalid", 1'b1, dbg_rvalid)
        `CHK("rdata", exp, dbg_rdata)
    endtask : rd_chk

    task automatic acc_chk(input logic [31:0] a, input logic w, input int sp,
                           input logic bd, input int ec, input int el);
        int code, lat, s0;
        s0 = strobes;
        core.access(a, w, fwd_space_t'(sp), bd, code, lat);
        `CHK("outcome", ec, code)
        `CHK("strobes", (ec == 0) ? 1 : 0, strobes - s0)
        `CHK("latency", el, lat)
        if (ec == 0) begin
            `CHK("offset", a[OFFS_W-1:0], flash_offset)
            `CHK("fwrite", w, flash_write)
        end
    endtask : acc_chk

    initial begin
        {reset_n, ctl_move_wr, dbg_wr, dbg_rd, bd_en_wr, bd_en_wdata} = 6'h0;
        clk_en = 1'b1;
        ctl_move_wdata = '0;
        dbg_wdata = '0;
        peripheral_space_base = 32'h4000_0000;
        mismatches = 0;
        checked = 0;
        // the window fields have no reset, so give them a known value once
        do_reset(7'h40);
        wr_reg(1, 32'h0);
        foreach (STRAPS[k]) begin
            do_reset(STRAPS[k]);
            exp_v = STRAPS[k][0] | STRAPS[k][6] | (STRAPS[k][5:3] == MODE_SINGLE_CHIP) |
                    (STRAPS[k][5:3] == MODE_MASTER && STRAPS[k][2:1] == BOOT_INTERNAL);
            `CHK("valid", exp_v, window_valid)
            `CHK("bd_en", 1'b0, back_door_enable)
            rd_chk({31'h0, exp_v});
        end
        $display("test straps done");
        wr_reg(0, 32'hffff_ffff);
        `CHK("wvalid", 1'b1, window_valid)
        rd_chk(~RSVD_MASK);
        wr_reg(1, 32'h0008_0000);
        rd_chk(32'h0008_0000);
        acc_chk(32'h0008_0010, 0, 4, 0, 2, 1);
        $display("test register done");
        wr_reg(0, 32'h0008_0001);
        acc_chk(32'h0008_1234, 0, 0, 0, 0, 3);
        acc_chk(32'h0008_5678, 1, 2, 0, 0, 3);
        acc_chk(32'h0000_1234, 0, 0, 0, 2, 1);
        acc_chk(32'h0010_0000, 0, 0, 0, 2, 1);
        wr_reg(0, 32'h0008_0101);
        acc_chk(32'h0008_0004, 1, 3, 0, 1, 1);
        acc_chk(32'h0008_0004, 0, 3, 0, 0, 3);
        for (int i = 0; i < 5; i++) begin
            wr_reg(0, 32'h0008_0001 | (32'h2 << i));
            acc_chk(32'h0008_0100, 0, i, 0, 2, 1);
            acc_chk(32'h0008_0100, 0, (i + 1) % 5, 0, 0, 3);
        end
        wr_reg(0, 32'hfff8_0001);
        acc_chk(32'hffff_fffc, 0, 1, 0, 0, 3);
        $display("test window done");
        acc_chk(32'h4400_0010, 0, 2, 1, 1, 1);
        wr_reg(2, 32'h1);
        `CHK("bd_en", 1'b1, back_door_enable)
        acc_chk(32'h4400_0010, 0, 2, 1, 0, 5);
        acc_chk(32'h4400_0020, 1, 2, 1, 0, 3);
        acc_chk(32'h4408_0000, 0, 2, 1, 1, 1);
        $display("test back door done");
        // a frozen clock enable must swallow a write
        clk_en = 1'b0;
        wr_reg(0, 32'h0000_0000);
        clk_en = 1'b1;
        rd_chk(32'hfff8_0001);
        $display("test clock enable done");
        do_reset(7'h00);
        `CHK("bd_en", 1'b0, back_door_enable)
        // base, protect and masks survive the reset; only valid follows the straps
        rd_chk(32'hfff8_0000);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : fwd_flash_window_tb
